// ===== bench/hlbc_link_partner.sv
// ==========================================
// far-side transmit pacing model
// ==========================================
// paces the transmitter: one unit done pulse each i_gap+1 active cycles
// a gap of zero would give back-to-back units; the bench keeps it at one or more
module hlbc_link_partner (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_tx_active,
    input wire logic [3:0] i_gap,
    output logic o_tx_unit_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_ff; // cycles spent on the unit in flight

    // a whole message or one repetition counts as one unit
    // one process drives the output and the counter, reset included, so nothing is multiply driven
    always @(posedge i_clock) begin
        if (i_reset) begin
            o_tx_unit_done <= 1'b0;
            wait_ff <= 4'h0;
        end else begin
            o_tx_unit_done <= 1'b0;
            if (!i_tx_active) begin
                wait_ff <= 4'h0; // idle: nothing is being sent
            end else if (wait_ff >= i_gap) begin
                o_tx_unit_done <= 1'b1;
                wait_ff <= 4'h0;
            end else begin
                wait_ff <= wait_ff + 4'h1;
            end
        end
    end
endmodule

// ===== bench/test_hlbc_link_buffer_count.sv
// ==========================================
// self-checking bench
// ==========================================
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end
module test_hlbc_link_buffer_count;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] a_ctrl = hlbc_pkg::CTRL_OFFSET;
    localparam logic [11:0] a_tx = hlbc_pkg::TX_COUNT_OFFSET;
    localparam logic [11:0] a_rx = hlbc_pkg::RX_COUNT_OFFSET;
    logic i_clock = 1'b0, i_reset = 1'b1, i_write = 1'b0, i_read = 1'b0;
    logic [11:0] addr = 12'h0000;
    logic [7:0] wdata = 8'h00;
    logic rx_done = 1'b0, rx_bos = 1'b0, rx_buf = 1'b0;
    logic [6:0] rx_bytes = 7'h00, n;
    logic [3:0] gap = 4'h1;
    wire logic [7:0] rdata;
    wire logic unit_done, tx_active, tx_idx, tx_bos, tx_irq, rx_ptr, rx_irq;
    wire logic [11:0] tx_base;
    wire logic [6:0] tx_len, rx_cnt;
    int err_total = 0, n_compared = 0, units = 0, last_units = 0;
    int tx_irqs = 0, rx_irqs = 0, mode, b, cnt, k0;

    always #10 i_clock = ~i_clock;

    hlbc_link_buffer_count DUT (.i_clock(i_clock), .i_reset(i_reset), .i_addr(addr),
        .i_wdata(wdata), .i_write(i_write), .i_read(i_read), .o_rdata(rdata),
        .i_tx_unit_done(unit_done), .o_tx_active(tx_active), .o_tx_buffer_index(tx_idx),
        .o_tx_buffer_base(tx_base), .o_tx_bit_oriented(tx_bos), .o_tx_length(tx_len),
        .o_tx_end_of_transfer_irq(tx_irq), .i_rx_frame_done(rx_done),
        .i_rx_frame_bit_oriented(rx_bos), .i_rx_frame_buffer(rx_buf),
        .i_rx_frame_bytes(rx_bytes), .o_rx_buffer_pointer(rx_ptr),
        .o_rx_message_count(rx_cnt), .o_rx_end_of_transfer_irq(rx_irq));
    hlbc_link_partner far_end (.i_clock(i_clock), .i_reset(i_reset), .i_tx_active(tx_active),
        .i_gap(gap), .o_tx_unit_done(unit_done));

    // units taken per transfer and interrupt pulses, counted on every rising edge
    always @(posedge i_clock) begin
        if (unit_done && tx_active) units = units + 1;
        if (tx_irq) begin
            tx_irqs++;
            last_units = units;
            units = 0;
        end
        if (rx_irq) rx_irqs++;
    end

    // ==========================================
    // bus and link tasks
    // ==========================================
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_clock);
        addr <= a;
        wdata <= d;
        i_write <= 1'b1;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask

    // read data stands only in the cycle after the read edge
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge i_clock);
        addr <= a;
        i_read <= 1'b1;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask

    task automatic rxf(input logic bit_oriented_signaling, input logic bf, input logic [6:0] sz);
        @(posedge i_clock);
        {rx_done, rx_bos, rx_buf, rx_bytes} <= {1'b1, bit_oriented_signaling, bf, sz};
        @(posedge i_clock);
        rx_done <= 1'b0;
    endtask

    // bounded wait for the k-th transmit interrupt
    task automatic wait_tx(input int k);
        repeat (300) if (tx_irqs < k) @(posedge i_clock);
        #1;
        `CHK(tx_irqs, k)
    endtask

    task automatic tally_and_finish;
        if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // hang guard: far beyond the few hundred cycles the tests need
    initial begin
        #400000;
        err_total++;
        tally_and_finish();
    end

    // ==========================================
    // main sequence
    // ==========================================
    initial begin
        void'($urandom(32'ha873));
        repeat (3) @(posedge i_clock);
        i_reset <= 1'b0;
        #1;
        `CHK(tx_base, hlbc_pkg::TX_BUF0_BASE)
        rd(a_ctrl, 8'h00);
        rd(a_tx, 8'h00);
        rd(a_rx, 8'h00);
        wr(12'h0116, 8'hff); // unmapped write is dropped
        rd(12'h0116, 8'h00);
        rd(a_rx, 8'h00);
        // random transfers in both signaling types, mixed pacing
        for (int k = 0; k < 6; k++) begin
            mode = $urandom % 2;
            b = $urandom % 2;
            cnt = 2 + $urandom % 4;
            gap <= 4'(1 + $urandom % 3);
            wr(a_ctrl, {7'h00, 1'(mode)});
            wr(a_tx, {1'(b), 7'(cnt)});
            rd(a_tx, {~1'(b), 7'(cnt)});
            @(posedge i_clock);
            #1;
            `CHK({tx_active, tx_idx, tx_bos, tx_len}, {1'b1, 1'(b), ~1'(mode), 7'(cnt)})
            `CHK(tx_base, b ? hlbc_pkg::TX_BUF1_BASE : hlbc_pkg::TX_BUF0_BASE)
            wait_tx(tx_irqs + 1);
            `CHK(last_units, mode ? 1 : cnt)
            `CHK(tx_active, 1'b0)
        end
        // zero count repeats with no end until another buffer is queued
        wr(a_ctrl, 8'h00);
        k0 = tx_irqs;
        wr(a_tx, 8'h00);
        repeat (40) @(posedge i_clock);
        #1;
        `CHK({tx_active, tx_idx}, 2'b10)
        `CHK(tx_irqs, k0)
        wr(a_tx, 8'h82);
        wait_tx(k0 + 2);
        `CHK(last_units, 2)
        // receive: repetition target, endless target, message size
        wr(a_rx, 8'h02);
        rxf(1'b1, 1'b1, 7'h00);
        rxf(1'b1, 1'b0, 7'h00);
        @(posedge i_clock);
        #1;
        `CHK(rx_irqs, 1)
        `CHK(rx_ptr, 1'b0)
        wr(a_rx, 8'h00);
        repeat (3) rxf(1'b1, 1'b1, 7'h00);
        @(posedge i_clock);
        #1;
        `CHK(rx_irqs, 1)
        n = 7'(3 + $urandom % 120);
        rxf(1'b0, 1'b1, n);
        #1;
        `CHK({rx_ptr, rx_cnt}, {1'b1, n})
        rd(a_rx, {1'b1, n});
        @(posedge i_clock);
        #1;
        `CHK(rdata, 8'h00)
        tally_and_finish();
    end
endmodule

// ===== rtl/hlbc_link_buffer_count.sv
// Functional notes
// R01 - select bit picks transmit buffer zero or one
// R02 - select bit read returns next free buffer
// R03 - busy buffer never reported; never reselect it (the code names the queued busy buffer when both are busy)
// R04 - bit oriented: repeat count then interrupt, halt
// R05 - bit oriented zero count repeats without end (the code ends it, with an interrupt, once the other buffer is queued)
// R06 - message oriented count is length without checksum
// R07 - receive pointer names buffer with newest message
// R08 - receive count sets repetitions before interrupt
// R09 - zero receive count: endless, no interrupt
// R10 - message oriented: device writes received byte size
// R11 - type bit zero bit oriented, one message
// R12 - fill buffer before writing count and select
//
// Our own choice: the address-and-strobe port.
module hlbc_link_buffer_count (
    input wire logic i_clock,
    input wire logic i_reset,
    // register port
    input wire logic [11:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [7:0] o_rdata,
    // transmit controller side
    input wire logic i_tx_unit_done,
    output logic o_tx_active,
    output logic o_tx_buffer_index,
    output logic [11:0] o_tx_buffer_base,
    output logic o_tx_bit_oriented,
    output logic [6:0] o_tx_length,
    output logic o_tx_end_of_transfer_irq,
    // receive controller side
    input wire logic i_rx_frame_done,
    input wire logic i_rx_frame_bit_oriented,
    input wire logic i_rx_frame_buffer,
    input wire logic [6:0] i_rx_frame_bytes,
    output logic o_rx_buffer_pointer,
    output logic [6:0] o_rx_message_count,
    output logic o_rx_end_of_transfer_irq
);

    // ======================================================================
    // state record
    // ======================================================================
    typedef struct packed {
        logic [7:0] rdata; // read answer, valid one cycle
        logic signaling_type_select; // 0 bit oriented, 1 message oriented
        logic [6:0] tx_message_count; // last count written by software
        logic [1:0] busy; // buffer holds a message not yet consumed
        logic [1:0][6:0] len; // count captured per buffer
        logic [1:0] message_oriented_signaling; // type captured per buffer
        logic active; // a buffer is being sent
        logic cur; // buffer being sent
        logic [11:0] base; // base address of buffer being sent
        logic [6:0] cur_len; // count of buffer being sent
        logic cur_mos; // type of buffer being sent
        logic [6:0] rep; // repetitions sent so far
        logic tx_irq; // transmit end pulse
        logic rx_buffer_pointer; // buffer with newest message
        logic [6:0] rx_message_count; // target or received size
        logic [6:0] rx_rep; // bit oriented repetitions received
        logic rx_irq; // receive end pulse
    } hlbc_state_type;

    hlbc_state_type state_ff;
    hlbc_state_type nxt_state;

    // next available buffer as seen by software
    logic tx_avail;
    logic tx_done_now;
    logic [6:0] rep_inc;
    logic [6:0] rx_rep_inc;

    // ======================================================================
    // next available buffer
    // ======================================================================
    // the buffer on the line is never offered; when both
    // are busy the one not on the line is named, it goes on the line next
    always_comb begin
        if (state_ff.busy == 2'b01) begin
            tx_avail = 1'b1; // R02
        end else if (state_ff.busy == 2'b10) begin
            tx_avail = 1'b0; // R02
        end else if (state_ff.busy == 2'b11) begin
            tx_avail = ~state_ff.cur; // R03
        end else begin
            tx_avail = 1'b0;
        end
    end

    // ======================================================================
    // next state
    // ======================================================================
    always_comb begin
        nxt_state = state_ff;
        rep_inc = state_ff.rep + 7'h01;
        rx_rep_inc = state_ff.rx_rep + 7'h01;
        tx_done_now = 1'b0;
        nxt_state.tx_irq = 1'b0;
        nxt_state.rx_irq = 1'b0;
        nxt_state.rdata = hlbc_pkg::RDATA_IDLE;

        // read answer, taken from state before this cycle's updates
        if (i_read) begin
            if (i_addr == hlbc_pkg::TX_COUNT_OFFSET) begin
                nxt_state.rdata = {tx_avail, state_ff.tx_message_count}; // R02
            end else if (i_addr == hlbc_pkg::RX_COUNT_OFFSET) begin
                nxt_state.rdata = {state_ff.rx_buffer_pointer, state_ff.rx_message_count};
            end else if (i_addr == hlbc_pkg::CTRL_OFFSET) begin
                nxt_state.rdata = {7'h00, state_ff.signaling_type_select};
            end else begin
                nxt_state.rdata = hlbc_pkg::RDATA_IDLE; // unmapped reads zero
            end
        end

        // transmit progress: one repetition or one whole message consumed
        if (state_ff.active && i_tx_unit_done) begin
            if (state_ff.cur_mos) begin
                tx_done_now = 1'b1; // message read out once
            end else if (state_ff.cur_len == 7'h00) begin
                // endless repeat; only a queued buffer may take over
                tx_done_now = state_ff.busy[~state_ff.cur]; // R05
            end else if (rep_inc == state_ff.cur_len) begin
                tx_done_now = 1'b1; // R04
            end
            nxt_state.rep = rep_inc;
            if (tx_done_now) begin
                nxt_state.active = 1'b0; // R04
                nxt_state.busy[state_ff.cur] = 1'b0;
                nxt_state.tx_irq = 1'b1; // R04
                nxt_state.rep = 7'h00;
            end
        end

        // start the next buffer; the queued one goes before a stale one
        if (!state_ff.active && (state_ff.busy != 2'b00)) begin
            nxt_state.active = 1'b1;
            nxt_state.cur = state_ff.busy[~state_ff.cur] ? ~state_ff.cur : state_ff.cur;
            nxt_state.base = nxt_state.cur ? hlbc_pkg::TX_BUF1_BASE
                                           : hlbc_pkg::TX_BUF0_BASE; // R01
            nxt_state.cur_len = state_ff.len[nxt_state.cur];
            nxt_state.cur_mos = state_ff.message_oriented_signaling[nxt_state.cur];
            nxt_state.rep = 7'h00;
        end

        // software writes; a write of the select bit hands over a buffer
        if (i_write) begin
            if (i_addr == hlbc_pkg::TX_COUNT_OFFSET) begin
                // buffer contents are assumed complete at this point
                nxt_state.tx_message_count = i_wdata[6:0]; // R12
                nxt_state.len[i_wdata[hlbc_pkg::SEL_BIT]] = i_wdata[6:0]; // R06
                nxt_state.message_oriented_signaling[i_wdata[hlbc_pkg::SEL_BIT]] = state_ff.signaling_type_select;
                // set wins over a release in the same cycle
                nxt_state.busy[i_wdata[hlbc_pkg::SEL_BIT]] = 1'b1; // R01
            end else if (i_addr == hlbc_pkg::RX_COUNT_OFFSET) begin
                nxt_state.rx_buffer_pointer = i_wdata[hlbc_pkg::SEL_BIT];
                nxt_state.rx_message_count = i_wdata[6:0]; // R08
                nxt_state.rx_rep = 7'h00;
            end else if (i_addr == hlbc_pkg::CTRL_OFFSET) begin
                nxt_state.signaling_type_select = i_wdata[hlbc_pkg::TYPE_BIT]; // R11
            end
        end

        // receive side; hardware updates win over a software write
        if (i_rx_frame_done) begin
            nxt_state.rx_buffer_pointer = i_rx_frame_buffer; // R07
            if (!i_rx_frame_bit_oriented) begin
                nxt_state.rx_message_count = i_rx_frame_bytes; // R10
            end else if (state_ff.rx_message_count == 7'h00) begin
                nxt_state.rx_rep = 7'h00; // R09
            end else if (rx_rep_inc == state_ff.rx_message_count) begin
                nxt_state.rx_irq = 1'b1; // R08
                nxt_state.rx_rep = 7'h00;
            end else begin
                nxt_state.rx_rep = rx_rep_inc;
            end
        end
    end

    // ======================================================================
    // state register
    // ======================================================================
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_ff <= '0;
            state_ff.tx_message_count <= hlbc_pkg::TX_COUNT_RESET[6:0];
            state_ff.signaling_type_select <= hlbc_pkg::CTRL_TYPE_RESET;
            state_ff.base <= hlbc_pkg::TX_BUF0_BASE;
            state_ff.rx_buffer_pointer <= hlbc_pkg::RX_COUNT_RESET[7];
            state_ff.rx_message_count <= hlbc_pkg::RX_COUNT_RESET[6:0];
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ======================================================================
    // outputs, all straight from the state register
    // ======================================================================
    assign o_rdata = state_ff.rdata;
    assign o_tx_active = state_ff.active;
    assign o_tx_buffer_index = state_ff.cur;
    assign o_tx_buffer_base = state_ff.base;
    assign o_tx_bit_oriented = ~state_ff.cur_mos;
    assign o_tx_length = state_ff.cur_len;
    assign o_tx_end_of_transfer_irq = state_ff.tx_irq;
    assign o_rx_buffer_pointer = state_ff.rx_buffer_pointer;
    assign o_rx_message_count = state_ff.rx_message_count;
    assign o_rx_end_of_transfer_irq = state_ff.rx_irq;

    // ======================================================================
    // assertions
    // ======================================================================
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    // the buffer on the line reads from its own base
    property p_tx_base;
        state_ff.active |-> (state_ff.base == (state_ff.cur ? hlbc_pkg::TX_BUF1_BASE
                                                             : hlbc_pkg::TX_BUF0_BASE));
    endproperty
    a_tx_base: assert property (p_tx_base) else $error("tx base mismatch"); // R01

    // select bit read returns the free buffer next cycle
    property p_avail_read;
        (i_read && i_addr == hlbc_pkg::TX_COUNT_OFFSET)
            |=> (o_rdata[hlbc_pkg::SEL_BIT] == $past(tx_avail));
    endproperty
    a_avail_read: assert property (p_avail_read) else $error("select read wrong"); // R02

    // the buffer on the line is never offered
    property p_not_in_use;
        state_ff.active |-> (tx_avail != state_ff.cur);
    endproperty
    a_not_in_use: assert property (p_not_in_use) else $error("busy buffer offered"); // R03

    // last counted repetition halts and pulses once
    property p_tx_count_end;
        (state_ff.active && i_tx_unit_done && !state_ff.cur_mos && state_ff.cur_len != 7'h00
            && rep_inc == state_ff.cur_len)
            |=> (o_tx_end_of_transfer_irq && !o_tx_active) ##1 !o_tx_end_of_transfer_irq;
    endproperty
    a_tx_count_end: assert property (p_tx_count_end) else $error("tx end missed"); // R04

    // zero count keeps repeating while nothing else is queued
    property p_tx_endless;
        (state_ff.active && !state_ff.cur_mos && state_ff.cur_len == 7'h00
            && !state_ff.busy[~state_ff.cur])
            |=> (o_tx_active && !o_tx_end_of_transfer_irq);
    endproperty
    a_tx_endless: assert property (p_tx_endless) else $error("endless repeat stopped"); // R05

    // pointer follows the buffer of the newest frame
    property p_rx_pointer;
        i_rx_frame_done |=> (o_rx_buffer_pointer == $past(i_rx_frame_buffer));
    endproperty
    a_rx_pointer: assert property (p_rx_pointer) else $error("rx pointer wrong"); // R07

    // receive interrupt exactly when the target is met
    property p_rx_count_end;
        (i_rx_frame_done && i_rx_frame_bit_oriented && state_ff.rx_message_count != 7'h00)
            |=> (o_rx_end_of_transfer_irq == ($past(rx_rep_inc) == $past(state_ff.rx_message_count)));
    endproperty
    a_rx_count_end: assert property (p_rx_count_end) else $error("rx end wrong"); // R08

    // zero target never interrupts
    property p_rx_endless;
        (state_ff.rx_message_count == 7'h00 && !i_write) |=> !o_rx_end_of_transfer_irq;
    endproperty
    a_rx_endless: assert property (p_rx_endless) else $error("rx irq at zero"); // R09

    // message size lands in the count field
    property p_rx_size;
        (i_rx_frame_done && !i_rx_frame_bit_oriented)
            |=> (o_rx_message_count == $past(i_rx_frame_bytes));
    endproperty
    a_rx_size: assert property (p_rx_size) else $error("rx size wrong"); // R10

    // a select write on an idle block puts that buffer on the line two edges on
    property p_tx_start;
        (i_write && i_addr == hlbc_pkg::TX_COUNT_OFFSET && !state_ff.active
            && state_ff.busy == 2'b00)
            |-> ##2 (o_tx_active && o_tx_buffer_index == $past(i_wdata[hlbc_pkg::SEL_BIT], 2));
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("selected buffer not sent"); // R01

    // a message oriented buffer is read out once, then the line is released
    property p_tx_mos_end;
        (state_ff.active && i_tx_unit_done && state_ff.cur_mos)
            |=> (o_tx_end_of_transfer_irq && !o_tx_active);
    endproperty
    a_tx_mos_end: assert property (p_tx_mos_end) else $error("message end missed"); // R01

    // the end of transfer pulse never stretches past one cycle
    property p_tx_irq_pulse;
        o_tx_end_of_transfer_irq |=> !o_tx_end_of_transfer_irq;
    endproperty
    a_tx_irq_pulse: assert property (p_tx_irq_pulse) else $error("tx irq too long"); // R04

    // read answer stands for one cycle only, idle value otherwise
    property p_rdata_idle;
        !i_read |=> (o_rdata == hlbc_pkg::RDATA_IDLE);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle"); // R02

endmodule

// ===== rtl/hlbc_pkg.sv
// ==========================================================================
// shared constants for the link buffer and count control block
// ==========================================================================
package hlbc_pkg;
    // register port geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int COUNT_W = 7;

    // register offsets within one channel
    localparam logic [11:0] CTRL_OFFSET = 12'h0113; // signaling type control
    localparam logic [11:0] TX_COUNT_OFFSET = 12'h0114; // transmit count and select
    localparam logic [11:0] RX_COUNT_OFFSET = 12'h0115; // receive count and pointer

    // field positions
    localparam int SEL_BIT = 7; // buffer select / pointer bit
    localparam int TYPE_BIT = 0; // signaling type select bit in control

    // transmit buffer base addresses inside the channel space
    localparam logic [11:0] TX_BUF0_BASE = 12'h0600;
    localparam logic [11:0] TX_BUF1_BASE = 12'h0700;

    // values after reset
    localparam logic [7:0] TX_COUNT_RESET = 8'h00;
    localparam logic [7:0] RX_COUNT_RESET = 8'h00;
    localparam logic CTRL_TYPE_RESET = 1'b0; // bit oriented after reset
    localparam logic [7:0] RDATA_IDLE = 8'h00;
endpackage
